// ===== hw/smr_top.sv
// Purpose: Stepper motion configuration, hold timer, backlash and command recorder.
// Assumes: Inputs synchronous to core_clk; registers reached over APB, zero wait.
// Notes:   Commands arrive as bytes in the command register; replay re-issues them.
// Functional notes
// - Step input active high by default; negative polarity bit stored only.
// - Direction high turns clockwise, low counterclockwise by default.
// - Direction polarity bit flips rotation produced by a high direction level.
// - Auto shut-off removes holding power after hold time once stepping ends.
// - Hold time counted in 0.1 second ticks, 0.1 s to 6000 s.
// - Backlash steps inserted after every direction reversal.
// - Acceleration 1 to 25000 accepted and stored but not applied.
// - Per-step travel held to convert position targets to step counts; stored only, no conversion is done.
// - Minimum pps stored as slow step rate for test and drive; stored but not applied.
// - Maximum pps stored as high step rate for test and drive; stored but not applied.
// - Ramp rate stored as acceleration for test, drive and position moves; stored but not applied.
// - Status shows busy while backlash steps or a replay are still executing.
// - About 1900 bytes of storage hold recorded command sequences.
// - While recording each command executes and is appended to storage until storage is full.
// - Replay starts on execute command or a falling edge on the trigger pin.
// - Arm bit gates the trigger pin; when off the pin is ignored.
// - Motor power restored on the next step input after shut-off.
// - Settings live until reset; save request latches a copy of the control bits that reset also clears.
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module smr_top
	import smr_pkg::*;
(
	// Clock and reset.
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	// APB slave.
	input  wire smr_pkg::smr_apb_req_s apb_req,
	output logic                      pready,
	output logic                      pslverr,
	output logic [31:0]               prdata,
	// Host step and direction, trigger pin.
	input  wire logic                 step_in,
	input  wire logic                 dir_in,
	input  wire logic                 replay_trigger_pin,
	// Motor power stage and busy flag.
	output smr_pkg::smr_motor_s       motor,
	output logic                      busy
);
	import smr_pkg::*;

	function automatic logic is_digit(input logic [7:0] c);
		return (c >= CH_ZERO) && (c <= CH_NINE);
	endfunction

	logic        ctrl_step_neg_ff, ctrl_dir_ccw_ff, ctrl_auto_off_ff, ctrl_arm_ff;
	logic [15:0] hold_ff, backlash_ff, accel_ff, minpps_ff, maxpps_ff, ramp_ff;
	logic [31:0] res_ff, param_ff, accum_ff, saved_ctrl_ff;
	logic        param_vld_ff;
	logic        wr_en, rd_en;
	logic [11:0] addr;
	logic [31:0] wdat;

	assign addr  = apb_req.paddr;
	assign wdat  = apb_req.pwdata;
	assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;
	assign rd_en = apb_req.psel & apb_req.penable & ~apb_req.pwrite;

	// Replay re-injects stored bytes through the same command path as the host.
	logic        cmd_vld;
	logic [7:0]  cmd_byte;
	smr_seq_e    seq_ff;
	logic [10:0] wptr_ff, rptr_ff;
	logic [7:0]  store_mem [STORE_BYTES];
	logic        store_full;

	assign store_full = (wptr_ff == 11'(STORE_BYTES));
	assign cmd_vld  = (wr_en && addr == OFS_CMD_CHAR && seq_ff != SQ_REPLAY) ||
	                  (seq_ff == SQ_REPLAY && rptr_ff != wptr_ff);
	assign cmd_byte = (seq_ff == SQ_REPLAY) ? store_mem[rptr_ff] : wdat[7:0];

	// Configuration registers.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_step_neg_ff <= 1'b0;
			ctrl_dir_ccw_ff  <= 1'b0;
			ctrl_auto_off_ff <= 1'b0;
			ctrl_arm_ff      <= 1'b0;
			hold_ff          <= RST_HOLD;
			backlash_ff      <= 16'h0000;
			accel_ff         <= RST_ACCEL;
			res_ff           <= RST_RES;
			minpps_ff        <= RST_MINPPS;
			maxpps_ff        <= RST_MAXPPS;
			ramp_ff          <= RST_RAMP;
		end else if (wr_en) begin
			unique case (addr)
				OFS_CTRL: begin
					ctrl_step_neg_ff <= wdat[CTRL_STEP_NEG];
					ctrl_dir_ccw_ff  <= wdat[CTRL_DIR_CCW];
					ctrl_auto_off_ff <= wdat[CTRL_AUTO_OFF];
					ctrl_arm_ff      <= wdat[CTRL_ARM];
				end
				OFS_HOLD: begin
					// Out-of-range values are clamped so the timer never sees zero.
					if (wdat[15:0] < HOLD_MIN)
						hold_ff <= HOLD_MIN;
					else if (wdat[15:0] > HOLD_MAX || wdat[31:16] != 16'h0000)
						hold_ff <= HOLD_MAX;
					else
						hold_ff <= wdat[15:0];
				end
				OFS_BACKLASH: backlash_ff <= wdat[15:0];
				OFS_ACCEL: begin
					if (wdat[15:0] >= ACCEL_MIN && wdat[15:0] <= ACCEL_MAX && wdat[31:16] == 16'h0000)
						accel_ff <= wdat[15:0];
				end
				OFS_RES:    res_ff    <= wdat;
				OFS_MINPPS: minpps_ff <= wdat[15:0];
				OFS_MAXPPS: maxpps_ff <= wdat[15:0];
				OFS_RAMP:   ramp_ff   <= wdat[15:0];
				default: ;
			endcase
		end
	end

	// Save copies the live control word; reset clears the copy along with the live values.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			saved_ctrl_ff <= 32'h0000_0000;
		else if (wr_en && addr == OFS_CTRL && wdat[CTRL_SAVE])
			saved_ctrl_ff <= {28'h0000000, ctrl_arm_ff, ctrl_auto_off_ff,
			                  ctrl_dir_ccw_ff, ctrl_step_neg_ff};
	end

	// Decimal parameter parser: digits accumulate, semicolon publishes.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			accum_ff     <= 32'h0000_0000;
			param_ff     <= 32'h0000_0000;
			param_vld_ff <= 1'b0;
		end else if (cmd_vld) begin
			if (is_digit(cmd_byte)) begin
				accum_ff <= 32'(accum_ff * 32'd10 + 32'(cmd_byte - CH_ZERO));
			end else if (cmd_byte == CH_SEMI) begin
				param_ff     <= accum_ff;
				param_vld_ff <= 1'b1;
				accum_ff     <= 32'h0000_0000;
			end
		end
	end

	// Sequence recorder.
	logic       trig_prev_ff, trig_fall;
	logic [1:0] seq_cmd;

	assign trig_fall = trig_prev_ff & ~replay_trigger_pin & ctrl_arm_ff;
	assign seq_cmd   = (wr_en && addr == OFS_SEQ) ? wdat[1:0] : 2'h0;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			trig_prev_ff <= 1'b1;
		else
			trig_prev_ff <= replay_trigger_pin;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			seq_ff  <= SQ_IDLE;
			wptr_ff <= 11'h000;
			rptr_ff <= 11'h000;
		end else begin
			unique case (seq_ff)
				SQ_IDLE: begin
					if (seq_cmd == SEQ_BEGIN) begin
						seq_ff  <= SQ_RECORD;
						wptr_ff <= 11'h000;
					end else if (seq_cmd == SEQ_EXEC || trig_fall) begin
						seq_ff  <= SQ_REPLAY;
						rptr_ff <= 11'h000;
					end
				end
				SQ_RECORD: begin
					if (seq_cmd == SEQ_HALT)
						seq_ff <= SQ_IDLE;
					else if (cmd_vld && !store_full)
						wptr_ff <= wptr_ff + 11'h001;
				end
				SQ_REPLAY: begin
					if (rptr_ff == wptr_ff)
						seq_ff <= SQ_IDLE;
					else
						rptr_ff <= rptr_ff + 11'h001;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (seq_ff == SQ_RECORD && cmd_vld && !store_full && seq_cmd != SEQ_HALT)
			store_mem[wptr_ff] <= cmd_byte;
	end

	// Step path with backlash insertion and hold timer.
	logic        step_prev_ff, step_edge, dir_cw, last_dir_ff;
	logic [15:0] blash_cnt_ff;
	logic [27:0] tick_cnt_ff;
	logic [15:0] hold_cnt_ff;
	logic        tick;
	logic        power_ff, step_out_ff, dir_out_ff, seen_step_ff;

	assign step_edge = step_in & ~step_prev_ff;
	assign dir_cw    = dir_in ^ ctrl_dir_ccw_ff;
	assign tick      = (tick_cnt_ff == 28'(TICK_CYC - 1));

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			step_prev_ff <= 1'b0;
		else
			step_prev_ff <= step_in;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			last_dir_ff  <= 1'b1;
			blash_cnt_ff <= 16'h0000;
			step_out_ff  <= 1'b0;
			dir_out_ff   <= 1'b1;
			seen_step_ff <= 1'b0;
		end else begin
			step_out_ff <= 1'b0;
			if (step_edge) begin
				dir_out_ff   <= dir_cw;
				seen_step_ff <= 1'b1;
				last_dir_ff  <= dir_cw;
				step_out_ff  <= 1'b1;
				if (seen_step_ff && dir_cw != last_dir_ff)
					blash_cnt_ff <= backlash_ff;
			end else if (blash_cnt_ff != 16'h0000 && !step_out_ff) begin
				step_out_ff  <= 1'b1;
				blash_cnt_ff <= blash_cnt_ff - 16'h0001;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_ff <= 28'h0000000;
			hold_cnt_ff <= 16'h0000;
			power_ff    <= 1'b1;
		end else if (step_edge || step_out_ff) begin
			tick_cnt_ff <= 28'h0000000;
			hold_cnt_ff <= 16'h0000;
			power_ff    <= 1'b1;
		end else if (wr_en && addr == OFS_CTRL && wdat[CTRL_MOTOR_OFF]) begin
			power_ff <= 1'b0;
		end else if (ctrl_auto_off_ff && power_ff) begin
			tick_cnt_ff <= tick ? 28'h0000000 : tick_cnt_ff + 28'h0000001;
			if (tick) begin
				if (hold_cnt_ff + 16'h0001 >= hold_ff)
					power_ff <= 1'b0;
				else
					hold_cnt_ff <= hold_cnt_ff + 16'h0001;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			motor <= '0;
			busy  <= 1'b0;
		end else begin
			motor.step     <= step_out_ff;
			motor.dir_cw   <= dir_out_ff;
			motor.power_on <= power_ff;
			busy <= (seq_ff == SQ_REPLAY) || (blash_cnt_ff != 16'h0000);
		end
	end

	// APB: zero wait states, unmapped reads return zero with an error.
	logic mapped;
	assign mapped = (addr[1:0] == 2'b00) && (addr <= OFS_SEQ);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= apb_req.psel & ~apb_req.penable;
			pslverr <= apb_req.psel & ~apb_req.penable & ~mapped;
			if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
				unique case (addr)
					OFS_CTRL:     prdata <= {26'h0, ~power_ff, 1'b0, ctrl_arm_ff,
					                         ctrl_auto_off_ff, ctrl_dir_ccw_ff, ctrl_step_neg_ff};
					OFS_HOLD:     prdata <= {16'h0, hold_ff};
					OFS_BACKLASH: prdata <= {16'h0, backlash_ff};
					OFS_ACCEL:    prdata <= {16'h0, accel_ff};
					OFS_RES:      prdata <= res_ff;
					OFS_MINPPS:   prdata <= {16'h0, minpps_ff};
					OFS_MAXPPS:   prdata <= {16'h0, maxpps_ff};
					OFS_RAMP:     prdata <= {16'h0, ramp_ff};
					OFS_STATUS:   prdata <= {16'h0, 5'h0, wptr_ff}
					                        | {28'h0, param_vld_ff, seq_ff[2], seq_ff[1],
					                           (seq_ff == SQ_REPLAY) || (blash_cnt_ff != 16'h0)} << 16;
					OFS_PARAM:    prdata <= param_ff;
					OFS_SEQ:      prdata <= saved_ctrl_ff;
					default:      prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Assertions.
	a_power_restore: assert property (@(posedge core_clk) disable iff (!rst_n)
		step_edge |=> power_ff) else $error("power not restored on step");
	a_dir_map: assert property (@(posedge core_clk) disable iff (!rst_n)
		step_edge |-> ##2 motor.dir_cw == $past(dir_cw, 2))
		else $error("direction mapping wrong");
	a_backlash_load: assert property (@(posedge core_clk) disable iff (!rst_n)
		step_edge && seen_step_ff && dir_cw != last_dir_ff |=> blash_cnt_ff == $past(backlash_ff))
		else $error("backlash not loaded");
	a_step_pass: assert property (@(posedge core_clk) disable iff (!rst_n)
		step_edge |=> step_out_ff) else $error("step not forwarded");
	a_hold_range: assert property (@(posedge core_clk) disable iff (!rst_n)
		hold_ff >= HOLD_MIN && hold_ff <= HOLD_MAX) else $error("hold out of range");
	a_accel_range: assert property (@(posedge core_clk) disable iff (!rst_n)
		accel_ff >= ACCEL_MIN && accel_ff <= ACCEL_MAX) else $error("accel out of range");
	a_trig_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
		seq_ff == SQ_IDLE && !ctrl_arm_ff && seq_cmd == 2'h0 |=> seq_ff != SQ_REPLAY)
		else $error("trigger not gated");
	a_busy_replay: assert property (@(posedge core_clk) disable iff (!rst_n)
		seq_ff == SQ_REPLAY |=> busy) else $error("busy missing in replay");
	a_record_append: assert property (@(posedge core_clk) disable iff (!rst_n)
		seq_ff == SQ_RECORD && cmd_vld && !store_full && seq_cmd != SEQ_HALT
		|=> wptr_ff == $past(wptr_ff) + 11'h001) else $error("record not appended");
	a_param_semi: assert property (@(posedge core_clk) disable iff (!rst_n)
		cmd_vld && cmd_byte == CH_SEMI |=> param_ff == $past(accum_ff))
		else $error("parameter not published");
	a_auto_off: assert property (@(posedge core_clk) disable iff (!rst_n)
		!ctrl_auto_off_ff && !(wr_en && addr == OFS_CTRL) && power_ff |=> power_ff)
		else $error("power dropped without auto off");

	c_replay:   cover property (@(posedge core_clk) disable iff (!rst_n)
		seq_ff == SQ_RECORD ##[1:50] seq_ff == SQ_REPLAY);
	c_backlash: cover property (@(posedge core_clk) disable iff (!rst_n)
		blash_cnt_ff != 16'h0000 ##1 blash_cnt_ff == 16'h0000);
	c_poweroff: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(power_ff));
	c_trigger:  cover property (@(posedge core_clk) disable iff (!rst_n) trig_fall);

endmodule
`default_nettype wire

// ===== hw/smr_pkg.sv
// Purpose: Shared constants and types for the stepper motion config recorder.
// Assumes: 250 MHz core clock, APB register access with 32-bit data.
// Notes:   Offsets are byte addresses of aligned words.
package smr_pkg;

	localparam int unsigned CLK_HZ          = 250_000_000;
	localparam int unsigned TICK_MS         = 100;
	localparam int unsigned TICK_CYC        = CLK_HZ / 1000 * TICK_MS;
	localparam logic [15:0] HOLD_MIN        = 16'h0001;
	localparam logic [15:0] HOLD_MAX        = 16'hEA60;
	localparam logic [15:0] ACCEL_MIN       = 16'h0001;
	localparam logic [15:0] ACCEL_MAX       = 16'h61A8;
	localparam int unsigned STORE_BYTES     = 1900;
	localparam int unsigned STORE_AW        = 11;

	localparam logic [11:0] OFS_CTRL        = 12'h000;
	localparam logic [11:0] OFS_HOLD        = 12'h004;
	localparam logic [11:0] OFS_BACKLASH    = 12'h008;
	localparam logic [11:0] OFS_ACCEL       = 12'h00C;
	localparam logic [11:0] OFS_RES         = 12'h010;
	localparam logic [11:0] OFS_MINPPS      = 12'h014;
	localparam logic [11:0] OFS_MAXPPS      = 12'h018;
	localparam logic [11:0] OFS_RAMP        = 12'h01C;
	localparam logic [11:0] OFS_STATUS      = 12'h020;
	localparam logic [11:0] OFS_CMD_CHAR    = 12'h024;
	localparam logic [11:0] OFS_PARAM       = 12'h028;
	localparam logic [11:0] OFS_SEQ         = 12'h02C;

	localparam int unsigned CTRL_STEP_NEG   = 0;
	localparam int unsigned CTRL_DIR_CCW    = 1;
	localparam int unsigned CTRL_AUTO_OFF   = 2;
	localparam int unsigned CTRL_ARM        = 3;
	localparam int unsigned CTRL_SAVE       = 4;
	localparam int unsigned CTRL_MOTOR_OFF  = 5;

	localparam logic [15:0] RST_HOLD        = 16'h000A;
	localparam logic [15:0] RST_MINPPS      = 16'h0014;
	localparam logic [15:0] RST_MAXPPS      = 16'h08FC;
	localparam logic [15:0] RST_RAMP        = 16'h0001;
	localparam logic [15:0] RST_ACCEL       = 16'h03E8;
	localparam logic [31:0] RST_RES         = 32'h0000_0001;

	localparam logic [7:0]  CH_SEMI         = 8'h3B;
	localparam logic [7:0]  CH_ZERO         = 8'h30;
	localparam logic [7:0]  CH_NINE         = 8'h39;

	localparam logic [1:0]  SEQ_BEGIN       = 2'h1;
	localparam logic [1:0]  SEQ_HALT        = 2'h2;
	localparam logic [1:0]  SEQ_EXEC        = 2'h3;

	typedef enum logic [2:0] {
		SQ_IDLE   = 3'b001,
		SQ_RECORD = 3'b010,
		SQ_REPLAY = 3'b100
	} smr_seq_e;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} smr_apb_req_s;

	typedef struct packed {
		logic        step;
		logic        dir_cw;
		logic        power_on;
	} smr_motor_s;

endpackage

// ===== verif/smr_host_model.sv
// Purpose: Host side model that drives step, direction and the replay trigger.
// Assumes: Lines change just after a rising edge; trigger idles high.
// Notes:   Steps are paced on busy; a new one waits up to 200 cycles for pending work to end.
`timescale 1ns/1ps
`default_nettype none
module smr_host_model (
	// Clock, reset and pacing.
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic busy,
	// Step, direction and trigger lines.
	output logic      step_in,
	output logic      dir_in,
	output logic      replay_trigger_pin
);
	// Counts steps issued after the busy wait ran out; the bench judges it.
	int n_late;

	initial begin
		step_in = 1'b0;
		dir_in = 1'b1;
		replay_trigger_pin = 1'b1;
	end

	// A long high time checks that only the rising edge counts as a step.
	task automatic step(input logic d, input int hi);
		int n;
		n = 0;
		while ((busy !== 1'b0 || rst_n !== 1'b1) && n < 200) begin
			@(posedge core_clk);
			n++;
		end
		if (busy !== 1'b0) n_late++;
		@(posedge core_clk);
		dir_in <= d;
		@(posedge core_clk);
		step_in <= 1'b1;
		repeat (hi) @(posedge core_clk);
		step_in <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic pull_trigger();
		@(posedge core_clk);
		replay_trigger_pin <= 1'b0;
		repeat (3) @(posedge core_clk);
		replay_trigger_pin <= 1'b1;
		@(posedge core_clk);
	endtask
endmodule
`default_nettype wire

// ===== verif/smr_top_tb_top.sv
// Purpose: Self-checking bench for the stepper config recorder.
// Assumes: Zero-wait APB slave; hold timer too long to run to expiry here.
// Notes:   Every scenario drives the block and judges the result itself.
`timescale 1ns/1ps
`default_nettype none
module smr_top_tb_top;
	import smr_pkg::*;
	logic         core_clk;
	logic         rst_n;
	smr_apb_req_s apb_req;
	logic         pready;
	logic         pslverr;
	logic [31:0]  prdata;
	logic         step_in;
	logic         dir_in;
	logic         replay_trigger_pin;
	smr_motor_s   motor;
	logic         busy;
	logic [31:0]  rd;
	logic         err;
	int           n_errors;
	int           n_tests;
	int           n_pulses;

	smr_top i_smr_top (.core_clk(core_clk), .rst_n(rst_n), .apb_req(apb_req),
		.pready(pready), .pslverr(pslverr), .prdata(prdata), .step_in(step_in),
		.dir_in(dir_in), .replay_trigger_pin(replay_trigger_pin), .motor(motor),
		.busy(busy));
	smr_host_model i_smr_host_model (.core_clk(core_clk), .rst_n(rst_n), .busy(busy),
		.step_in(step_in), .dir_in(dir_in), .replay_trigger_pin(replay_trigger_pin));

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		if (motor.step === 1'b1) n_pulses <= n_pulses + 1;
	end

	task automatic give_verdict();
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %b seen %b", what, exp, got);
		end
	endtask

	// The request stands until pready is seen high at a rising edge, or for 50 cycles at most.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge core_clk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) chk_bit("pready", 1'b1, pready);
		rd = prdata;
		err = pslverr;
		apb_req <= '0;
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		repeat (4) @(posedge core_clk);
		while (busy !== 1'b0 && n < 500) begin
			@(posedge core_clk);
			n++;
		end
		chk_bit("busy", 1'b0, busy);
		repeat (4) @(posedge core_clk);
	endtask

	task automatic send_text(input string s);
		for (int i = 0; i < s.len(); i++) apb(1'b1, OFS_CMD_CHAR, {24'h000000, s[i]});
	endtask

	task automatic t_reset_vals();
		logic [11:0] ofs [6];
		logic [31:0] val [6];
		ofs = '{OFS_HOLD, OFS_ACCEL, OFS_RES, OFS_MINPPS, OFS_MAXPPS, OFS_RAMP};
		val = '{{16'h0000, RST_HOLD}, {16'h0000, RST_ACCEL}, RST_RES,
			{16'h0000, RST_MINPPS}, {16'h0000, RST_MAXPPS}, {16'h0000, RST_RAMP}};
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, ofs[i], 32'h0);
			chk_word("reset value", val[i], rd);
			chk_bit("pslverr", 1'b0, err);
		end
	endtask

	task automatic t_unmapped();
		apb(1'b0, 12'h030, 32'h0);
		chk_bit("pslverr", 1'b1, err);
		chk_word("unmapped data", 32'h0, rd);
		apb(1'b1, 12'h006, 32'hFFFF_FFFF);
		chk_bit("pslverr", 1'b1, err);
	endtask

	task automatic t_ranges();
		logic [31:0] wv [6];
		logic [31:0] ev [6];
		logic [11:0] av [6];
		av = '{OFS_HOLD, OFS_HOLD, OFS_HOLD, OFS_ACCEL, OFS_ACCEL, OFS_ACCEL};
		wv = '{32'h0, 32'hEA61, 32'hEA60, 32'h61A9, 32'h61A8, 32'h0};
		ev = '{32'h1, 32'hEA60, 32'hEA60, 32'h3E8, 32'h61A8, 32'h61A8};
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, av[i], wv[i]);
			apb(1'b0, av[i], 32'h0);
			chk_word("range limit", ev[i], rd);
		end
	endtask

	task automatic t_direction();
		logic [2:0] dv;
		logic [2:0] cv;
		logic [2:0] ev;
		int         p0;
		dv = 3'b101;
		cv = 3'b100;
		ev = 3'b001;
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, OFS_CTRL, {30'h0, cv[i], 1'b0});
			p0 = n_pulses;
			i_smr_host_model.step(dv[i], 1 + 3 * i);
			wait_idle();
			chk_bit("dir_cw", ev[i], motor.dir_cw);
			chk_word("step pulses", 32'h1, n_pulses - p0);
		end
		apb(1'b1, OFS_CTRL, 32'h0);
		i_smr_host_model.step(1'b1, 2);
		wait_idle();
	endtask

	task automatic t_backlash();
		int p0;
		apb(1'b1, OFS_BACKLASH, 32'h3);
		p0 = n_pulses;
		i_smr_host_model.step(1'b1, 2);
		wait_idle();
		chk_word("same dir pulses", 32'h1, n_pulses - p0);
		p0 = n_pulses;
		i_smr_host_model.step(1'b0, 2);
		wait_idle();
		chk_word("reversal pulses", 32'h4, n_pulses - p0);
		apb(1'b1, OFS_BACKLASH, 32'h0);
	endtask

	task automatic t_power();
		apb(1'b1, OFS_CTRL, 32'h20);
		repeat (2) @(posedge core_clk);
		chk_bit("power_on", 1'b0, motor.power_on);
		apb(1'b0, OFS_CTRL, 32'h0);
		chk_bit("off flag", 1'b1, rd[CTRL_MOTOR_OFF]);
		i_smr_host_model.step(1'b0, 2);
		wait_idle();
		chk_bit("power_on", 1'b1, motor.power_on);
		// The save strobe copies the settings that stand before its own write.
		apb(1'b1, OFS_CTRL, 32'hA);
		apb(1'b1, OFS_CTRL, 32'h1A);
		apb(1'b0, OFS_SEQ, 32'h0);
		chk_word("saved ctrl", 32'hA, rd);
		apb(1'b1, OFS_CTRL, 32'h0);
	endtask

	task automatic t_parser();
		send_text("4096;");
		apb(1'b0, OFS_PARAM, 32'h0);
		chk_word("param", 32'd4096, rd);
		send_text("85");
		apb(1'b0, OFS_PARAM, 32'h0);
		chk_word("param held", 32'd4096, rd);
		send_text(";");
		apb(1'b0, OFS_PARAM, 32'h0);
		chk_word("param", 32'd85, rd);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk_bit("param valid", 1'b1, rd[19]);
	endtask

	task automatic t_record();
		apb(1'b1, OFS_SEQ, {30'h0, SEQ_BEGIN});
		send_text("12;");
		apb(1'b0, OFS_STATUS, 32'h0);
		chk_bit("recording", 1'b1, rd[17]);
		chk_word("record length", 32'd3, {21'h0, rd[10:0]});
		apb(1'b0, OFS_PARAM, 32'h0);
		chk_word("executed", 32'd12, rd);
		apb(1'b1, OFS_SEQ, {30'h0, SEQ_HALT});
		send_text("5;");
		apb(1'b1, OFS_SEQ, {30'h0, SEQ_EXEC});
		wait_idle();
		apb(1'b0, OFS_PARAM, 32'h0);
		chk_word("replayed", 32'd12, rd);
		send_text("5;");
		i_smr_host_model.pull_trigger();
		wait_idle();
		apb(1'b0, OFS_PARAM, 32'h0);
		chk_word("unarmed pin", 32'd5, rd);
		apb(1'b1, OFS_CTRL, 32'h8);
		i_smr_host_model.pull_trigger();
		wait_idle();
		apb(1'b0, OFS_PARAM, 32'h0);
		chk_word("armed pin", 32'd12, rd);
		apb(1'b1, OFS_CTRL, 32'h0);
	endtask

	initial begin
		rst_n = 1'b0;
		apb_req = '0;
		n_errors = 0;
		n_tests = 0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset_vals();
		t_unmapped();
		t_ranges();
		t_direction();
		t_backlash();
		t_power();
		t_parser();
		t_record();
		chk_word("pacing timeouts", 32'h0, i_smr_host_model.n_late);
		give_verdict();
	end

	// The scenarios need a few hundred cycles; this leaves ample margin.
	initial begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		give_verdict();
	end
endmodule
`default_nettype wire
